// file: src/tscm_params.svh
// Timing counts and sizes of the conflict monitor fault supervision
`ifndef TSCM_PARAMS_SVH
`define TSCM_PARAMS_SVH

`define TSCM_NUM_CH          12
`define TSCM_CLK_PERIOD_NS   40
`define TSCM_MS_NS           1000000
`define TSCM_MS_PER_S        1000
`define TSCM_CONFLICT_MS     325
`define TSCM_REDFAIL_MS      850
`define TSCM_LOWMAINS_MS     850
`define TSCM_DUAL_MS         850
`define TSCM_MINCLEAR_MS     2700
`define TSCM_WDOG_MS         1000
`define TSCM_MINFLASH_RST_S  4'h5
`define TSCM_TMR_W           12

`endif

// file: src/tscm_pkg.sv
// Types shared by the conflict monitor fault supervision logic
package tscm_pkg;

   typedef struct packed {
      logic [11:0] green;
      logic [11:0] yellow;
      logic [11:0] walk;
      logic [11:0] red;
   } tscm_lamps_type;

   typedef struct packed {
      logic              controllerHealth_n;
      logic              supplyPresence;
      logic              card_chain_presence_input;
      logic              lowMains;
      logic              watchdogIn;
      logic              manualReset;
   } tscm_supv_type;

   typedef struct packed {
      logic [11:0][11:0] compat;
      logic [11:0]       chanInclude;
      logic              minClearEn;
      logic              watchdogEn;
      logic              gwVsYellowEn;
      logic              vsRedEn;
      logic              walkExcludeB;
      logic [3:0]        minFlashSec;
   } tscm_opts_type;

   typedef struct packed {
      logic conflict;
      logic redFail;
      logic minClear;
      logic watchdog;
      logic dualInd;
      logic healthLost;
      logic supplyLost;
      logic cardLost;
      logic lowMains;
   } tscm_faults_type;

endpackage

// file: src/tscm_monitor.sv
// Fault supervision core of a twelve-channel traffic conflict monitor
// Function
// - Any enabled fault drops the output relay
// - Channel dark for 850 ms is red failure
// - Red failure latches until manual reset
// - Lost controller health forces non-latching flash
// - Lost supply or card chain forces flash
// - Relay returns automatically once non-latching faults clear
// - Low mains beyond 850 ms forces flash
// - Power interruption fault is non-latching
// - Relay held off for minimum flash after power-up
// - Four switches select 0 to 15 seconds
// - Conflicting green within 2.7 s is fault
// - Stalled watchdog square wave latches a fault
// - Green or walk with yellow latches fault
// - Green, walk or yellow with red latches
// - Baseline checks ignore channel switches and option switches one to four
// - Channel switches include channels in optional checks
// - Option switches one to four enable options
// - Switch B drops walk from red failure
// - Unpermitted concurrent non-red for 325 ms conflicts
// - Compatibility matrix permits channel pairs together
// - Conflicts latch; latch survives mains interruption
// - Timing halt asserted while faulted, removed after
`timescale 1ns/100ps
`default_nettype none
`include "tscm_params.svh"

module tscm_monitor
   import tscm_pkg::*;
#(
   parameter int CYC_PER_MS = `TSCM_MS_NS / `TSCM_CLK_PERIOD_NS,
   parameter int WDOG_MS    = `TSCM_WDOG_MS
) (
   input  wire logic           clk,
   input  wire logic           reset_n,
   input  wire tscm_lamps_type lampsIn,
   input  wire tscm_supv_type  supvIn,
   input  wire tscm_opts_type  optsIn,
   output var  logic           relayEnergize_q,
   output var  logic           timingHalt_q,
   output var  tscm_faults_type faults_q
);

   localparam int NCH = `TSCM_NUM_CH;
   localparam int TW  = `TSCM_TMR_W;
   localparam logic [TW-1:0] CONFLICT_LIM = TW'(`TSCM_CONFLICT_MS);
   localparam logic [TW-1:0] REDFAIL_LIM  = TW'(`TSCM_REDFAIL_MS);
   localparam logic [TW-1:0] LOWMAINS_LIM = TW'(`TSCM_LOWMAINS_MS);
   localparam logic [TW-1:0] DUAL_LIM     = TW'(`TSCM_DUAL_MS);
   localparam logic [TW-1:0] CLEAR_LIM    = TW'(`TSCM_MINCLEAR_MS);
   localparam logic [TW-1:0] WDOG_LIM     = TW'(WDOG_MS);
   localparam logic [9:0]    MS_PER_S     = 10'(`TSCM_MS_PER_S);
   // Healthy idle levels, so that no false supply loss follows reset
   localparam tscm_supv_type SUPV_IDLE    = '{supplyPresence: 1'b1,
                                              card_chain_presence_input: 1'b1,
                                              default: 1'b0};

   // Saturating ms timer that restarts whenever its condition drops
   function automatic logic [TW-1:0] tmrStep(input logic [TW-1:0] cnt,
                                             input logic cond,
                                             input logic tk,
                                             input logic [TW-1:0] lim);
      logic [TW-1:0] nxt;
      nxt = cnt;
      if (!cond) begin
         nxt = '0;
      end else if (tk && cnt < lim) begin
         nxt = cnt + TW'(1);
      end
      return nxt;
   endfunction

   // Two-stage synchronisers for every pin
   tscm_lamps_type lampsMeta_q, lamps_q;
   tscm_supv_type  supvMeta_q, supv_q;
   tscm_opts_type  optsMeta_q, opts_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lampsMeta_q <= '0;
         lamps_q     <= '0;
         supvMeta_q  <= SUPV_IDLE;
         supv_q      <= SUPV_IDLE;
         optsMeta_q  <= '0;
         opts_q      <= '0;
      end else begin
         lampsMeta_q <= lampsIn;
         lamps_q     <= lampsMeta_q;
         supvMeta_q  <= supvIn;
         supv_q      <= supvMeta_q;
         optsMeta_q  <= optsIn;
         opts_q      <= optsMeta_q;
      end
   end

   // Millisecond tick
   logic [$clog2(CYC_PER_MS)-1:0] divCnt_q;
   logic                          msTick_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         divCnt_q <= '0;
         msTick_q <= 1'b0;
      end else if (divCnt_q == ($clog2(CYC_PER_MS))'(CYC_PER_MS - 1)) begin
         divCnt_q <= '0;
         msTick_q <= 1'b1;
      end else begin
         divCnt_q <= divCnt_q + 1'b1;
         msTick_q <= 1'b0;
      end
   end

   // Green edge history and time since each green ended
   logic [NCH-1:0]          greenPrev_q;
   logic [NCH-1:0][TW-1:0]  clrCnt_q;

   // Per-channel conditions, plus the combined conflict and clearance flags
   logic [NCH-1:0] nonRed, darkNow, dualNow, greenRise;
   logic           conflictNow;
   logic           clearViol;

   always_comb begin
      conflictNow = 1'b0;
      clearViol   = 1'b0;
      for (int i = 0; i < NCH; i++) begin
         nonRed[i] = lamps_q.green[i] | lamps_q.yellow[i] | lamps_q.walk[i];
         // Option B takes walk out of the red failure decision
         darkNow[i] = ~(lamps_q.green[i] | lamps_q.yellow[i] | lamps_q.red[i]
                      | (lamps_q.walk[i] & ~opts_q.walkExcludeB));
         dualNow[i] = opts_q.chanInclude[i] &
                      ((opts_q.gwVsYellowEn & (lamps_q.green[i] | lamps_q.walk[i])
                        & lamps_q.yellow[i]) |
                       (opts_q.vsRedEn & nonRed[i] & lamps_q.red[i]));
      end
      for (int i = 0; i < NCH; i++) begin
         for (int j = 0; j < NCH; j++) begin
            if (i < j && nonRed[i] && nonRed[j]
                && !opts_q.compat[i][j] && !opts_q.compat[j][i]) begin
               conflictNow = 1'b1;
            end
            if (i != j && greenRise[j] && opts_q.chanInclude[i]
                && opts_q.chanInclude[j] && !opts_q.compat[i][j]
                && !opts_q.compat[j][i] && clrCnt_q[i] < CLEAR_LIM) begin
               clearViol = 1'b1;
            end
         end
      end
   end

   assign greenRise = lamps_q.green & ~greenPrev_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         greenPrev_q <= '0;
         // Saturated so the first green after power-up is not flagged
         clrCnt_q    <= {NCH{CLEAR_LIM}};
      end else begin
         greenPrev_q <= lamps_q.green;
         for (int i = 0; i < NCH; i++) begin
            if (lamps_q.green[i]) begin
               clrCnt_q[i] <= '0;
            end else if (msTick_q && clrCnt_q[i] < CLEAR_LIM) begin
               clrCnt_q[i] <= clrCnt_q[i] + TW'(1);
            end
         end
      end
   end

   // Fault timers
   logic [TW-1:0]          conflictCnt_q, lowMainsCnt_q, wdogCnt_q;
   logic [NCH-1:0][TW-1:0] darkCnt_q, dualCnt_q;
   logic                   wdogPrev_q;
   logic                   wdogEdge;

   assign wdogEdge = supv_q.watchdogIn ^ wdogPrev_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         conflictCnt_q <= '0;
         lowMainsCnt_q <= '0;
         darkCnt_q     <= '0;
         dualCnt_q     <= '0;
      end else begin
         conflictCnt_q <= tmrStep(conflictCnt_q, conflictNow, msTick_q, CONFLICT_LIM);
         lowMainsCnt_q <= tmrStep(lowMainsCnt_q, supv_q.lowMains, msTick_q,
                                  LOWMAINS_LIM);
         for (int i = 0; i < NCH; i++) begin
            darkCnt_q[i] <= tmrStep(darkCnt_q[i], darkNow[i], msTick_q, REDFAIL_LIM);
            dualCnt_q[i] <= tmrStep(dualCnt_q[i], dualNow[i], msTick_q, DUAL_LIM);
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wdogPrev_q <= 1'b0;
         wdogCnt_q  <= '0;
      end else begin
         wdogPrev_q <= supv_q.watchdogIn;
         wdogCnt_q  <= tmrStep(wdogCnt_q, !wdogEdge, msTick_q, WDOG_LIM);
      end
   end

   logic [NCH-1:0] darkHit, dualHit;

   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         darkHit[i] = darkCnt_q[i] == REDFAIL_LIM;
         dualHit[i] = dualCnt_q[i] == DUAL_LIM;
      end
   end

   // Latched faults: set wins over manual reset; only power-up clears too
   tscm_faults_type faultsNext;
   logic            latchedAny, liveAny;

   always_comb begin
      faultsNext = faults_q;
      faultsNext.conflict = (conflictCnt_q == CONFLICT_LIM)
                          | (faults_q.conflict & ~supv_q.manualReset);
      faultsNext.redFail  = (|darkHit)
                          | (faults_q.redFail & ~supv_q.manualReset);
      faultsNext.minClear = (clearViol & opts_q.minClearEn)
                          | (faults_q.minClear & ~supv_q.manualReset);
      faultsNext.watchdog = (wdogCnt_q == WDOG_LIM && opts_q.watchdogEn)
                          | (faults_q.watchdog & ~supv_q.manualReset);
      faultsNext.dualInd  = (|dualHit)
                          | (faults_q.dualInd & ~supv_q.manualReset);
      faultsNext.healthLost = supv_q.controllerHealth_n;
      faultsNext.supplyLost = ~supv_q.supplyPresence;
      faultsNext.cardLost   = ~supv_q.card_chain_presence_input;
      faultsNext.lowMains   = lowMainsCnt_q == LOWMAINS_LIM;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         faults_q <= '0;
      end else begin
         faults_q <= faultsNext;
      end
   end

   assign latchedAny = faults_q.conflict | faults_q.redFail | faults_q.minClear
                     | faults_q.watchdog | faults_q.dualInd;
   assign liveAny    = faults_q.healthLost | faults_q.supplyLost | faults_q.cardLost
                     | faults_q.lowMains;

   // Minimum flash after power-up, counted in whole seconds
   logic [9:0] msInSec_q;
   logic [3:0] secCnt_q;
   logic       minFlashDone_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         msInSec_q      <= '0;
         secCnt_q       <= '0;
         minFlashDone_q <= 1'b0;
      end else if (!minFlashDone_q && msTick_q) begin
         // Decided on ticks only: the switches read zero until synchronised
         if (secCnt_q >= opts_q.minFlashSec) begin
            minFlashDone_q <= 1'b1;
         end else if (msInSec_q == MS_PER_S - 10'h001) begin
            msInSec_q <= '0;
            secCnt_q  <= secCnt_q + 4'h1;
         end else begin
            msInSec_q <= msInSec_q + 10'h001;
         end
      end
   end

   // Relay and timing halt
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         relayEnergize_q <= 1'b0;
         timingHalt_q    <= 1'b0;
      end else begin
         relayEnergize_q <= minFlashDone_q && !latchedAny && !liveAny;
         timingHalt_q    <= latchedAny || liveAny;
      end
   end

   // Checks
   a_relay_fault_drop: assert property (@(posedge clk) disable iff (!reset_n)
      (latchedAny || liveAny) |=> !relayEnergize_q)
      else $error("Relay energised while a fault stands");

   a_redfail_latch_hold: assert property (@(posedge clk) disable iff (!reset_n)
      faults_q.redFail && !supv_q.manualReset |=> faults_q.redFail)
      else $error("Red failure dropped without manual reset");

   a_conflict_latch_hold: assert property (@(posedge clk) disable iff (!reset_n)
      faults_q.conflict && !supv_q.manualReset |=> faults_q.conflict)
      else $error("Conflict dropped without manual reset");

   a_health_nonlatch: assert property (@(posedge clk) disable iff (!reset_n)
      supv_q.controllerHealth_n |=> faults_q.healthLost ##1 !relayEnergize_q)
      else $error("Controller health loss did not force flash");

   a_auto_release: assert property (@(posedge clk) disable iff (!reset_n)
      minFlashDone_q && !latchedAny && !liveAny |=> relayEnergize_q)
      else $error("Relay not released once faults cleared");

   a_minflash_hold: assert property (@(posedge clk) disable iff (!reset_n)
      !minFlashDone_q |=> !relayEnergize_q)
      else $error("Relay energised during minimum flash");

   a_halt_tracks: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(latchedAny || liveAny) |=> timingHalt_q && !relayEnergize_q)
      else $error("Timing halt missing on fault");

   a_conflict_cause: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(faults_q.conflict) |-> $past(conflictNow, 2))
      else $error("Conflict raised without concurrent indications");

   a_watchdog_gate: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(faults_q.watchdog) |-> $past(opts_q.watchdogEn))
      else $error("Watchdog fault with option off");

   a_dark_restart: assert property (@(posedge clk) disable iff (!reset_n)
      !darkNow[0] |=> darkCnt_q[0] == '0)
      else $error("Red failure timer did not restart");

endmodule
`default_nettype wire

// file: verification/tscm_ctrl_model.sv
// Controller unit model: health output and flashing-logic square wave
`timescale 1ns/100ps
`default_nettype none

module tscm_ctrl_model #(
   parameter int HALF_PER = 8
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic failCmd,
   input  wire logic stallCmd,
   output var  logic health_n,
   output var  logic flashWave
);
   logic [7:0] cnt_q;

   // Healthy controller holds the signal asserted low
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         health_n <= 1'b0;
      end else begin
         health_n <= failCmd;
      end
   end

   // A stalled wave holds its level, which is what a hung controller shows
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 8'h00;
         flashWave <= 1'b0;
      end else if (!stallCmd) begin
         if (cnt_q == 8'(HALF_PER - 1)) begin
            cnt_q <= 8'h00;
            flashWave <= ~flashWave;
         end else begin
            cnt_q <= cnt_q + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the conflict monitor fault supervision
`timescale 1ns/100ps
`default_nettype none

module tb
   import tscm_pkg::*;
;
   localparam int MS = 4;
   localparam int RLY = 10;
   localparam int HLT = 9;
   localparam int CFL = 8;
   localparam int RDF = 7;
   localparam int MCL = 6;
   localparam int WDG = 5;
   localparam int DUL = 4;
   localparam int LMN = 0;
   logic            clk = 1'b0;
   logic            reset_n = 1'b0;
   tscm_lamps_type  lamps;
   tscm_opts_type   opts;
   tscm_supv_type   supv;
   tscm_faults_type faults_q;
   logic            failCmd, stallCmd, supplyOk, cardOk, lowMains, manRst;
   logic            health_n, flashWave, relayEnergize_q, timingHalt_q;
   logic [10:0]     obs;
   int              mismatches = 0;
   int              num_checks = 0;
   string           nm [11] = '{"lowMains", "cardLost", "supplyLost", "healthLost",
      "dualInd", "watchdog", "minClear", "redFail", "conflict", "timingHalt", "relay"};

   always #20 clk = ~clk;
   assign supv = {health_n, supplyOk, cardOk, lowMains, flashWave, manRst};
   assign obs = {relayEnergize_q, timingHalt_q, faults_q};

   tscm_monitor #(.CYC_PER_MS(MS), .WDOG_MS(20)) u_tscm_monitor (
      .clk(clk), .reset_n(reset_n), .lampsIn(lamps), .supvIn(supv), .optsIn(opts),
      .relayEnergize_q(relayEnergize_q), .timingHalt_q(timingHalt_q), .faults_q(faults_q));

   tscm_ctrl_model u_tscm_ctrl_model (
      .clk(clk), .reset_n(reset_n), .failCmd(failCmd), .stallCmd(stallCmd),
      .health_n(health_n), .flashWave(flashWave));

   // Samples at the falling edge so outputs have settled, returns on a rising edge
   task automatic at(input int n, input int sel, input logic exp);
      repeat (n) @(posedge clk);
      @(negedge clk);
      num_checks++;
      if (obs[sel] !== exp) begin
         mismatches++;
         $display("ERROR %s expected %b seen %b", nm[sel], exp, obs[sel]);
      end
      @(posedge clk);
   endtask

   task automatic clr();
      manRst <= 1'b1;
      repeat (6) @(posedge clk);
      manRst <= 1'b0;
   endtask

   task automatic done(input string name);
      $display("Test %s finished", name);
   endtask

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      lamps = '0;
      lamps.red = 12'hFFF;
      opts = '0;
      opts.chanInclude = 12'hFFF;
      opts.minFlashSec = 4'h1;
      {failCmd, stallCmd, lowMains, manRst} = 4'h0;
      {supplyOk, cardOk} = 2'h3;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      at(1000 * MS - 25, RLY, 1'b0);
      at(0, HLT, 1'b0);
      at(40, RLY, 1'b1);
      done("min flash");
      failCmd <= 1'b1;
      at(5, 3, 1'b1);
      at(0, RLY, 1'b0);
      at(0, HLT, 1'b1);
      failCmd <= 1'b0;
      at(6, RLY, 1'b1);
      at(0, HLT, 1'b0);
      for (int i = 0; i < 2; i++) begin
         if (i == 0) supplyOk <= 1'b0;
         else cardOk <= 1'b0;
         at(5, 2 - i, 1'b1);
         at(0, RLY, 1'b0);
         {supplyOk, cardOk} <= 2'h3;
         at(6, RLY, 1'b1);
      end
      done("health and supply");
      lowMains <= 1'b1;
      at(850 * MS - 20, RLY, 1'b1);
      at(40, RLY, 1'b0);
      lowMains <= 1'b0;
      at(6, RLY, 1'b1);
      done("low mains");
      opts.minClearEn <= 1'b1;
      lamps.green[0] <= 1'b1;
      at(10, MCL, 1'b0);
      lamps.green[0] <= 1'b0;
      at(2800 * MS, MCL, 1'b0);
      lamps.green[1] <= 1'b1;
      at(20, MCL, 1'b0);
      lamps.green[1] <= 1'b0;
      at(1000 * MS, MCL, 1'b0);
      lamps.green[0] <= 1'b1;
      at(20, MCL, 1'b1);
      lamps.green[0] <= 1'b0;
      opts.minClearEn <= 1'b0;
      clr();
      at(4, MCL, 1'b0);
      done("min clearance");
      lamps.red[2] <= 1'b0;
      lamps.walk[2] <= 1'b1;
      at(900 * MS, RDF, 1'b0);
      opts.walkExcludeB <= 1'b1;
      at(850 * MS - 20, RDF, 1'b0);
      at(40, RDF, 1'b1);
      at(0, RLY, 1'b0);
      lamps.red[2] <= 1'b1;
      lamps.walk[2] <= 1'b0;
      at(20, RDF, 1'b1);
      clr();
      at(4, RLY, 1'b1);
      done("red failure");
      lamps.green[1:0] <= 2'h3;
      at(325 * MS - 20, CFL, 1'b0);
      at(40, CFL, 1'b1);
      lamps.green[1:0] <= 2'h0;
      lowMains <= 1'b1;
      at(900 * MS, RLY, 1'b0);
      lowMains <= 1'b0;
      at(20, CFL, 1'b1);
      at(0, RLY, 1'b0);
      clr();
      at(4, RLY, 1'b1);
      opts.compat[0][1] <= 1'b1;
      lamps.green[1:0] <= 2'h3;
      at(400 * MS, CFL, 1'b0);
      lamps.green[1:0] <= 2'h0;
      done("conflict");
      opts.gwVsYellowEn <= 1'b1;
      lamps.green[3] <= 1'b1;
      lamps.yellow[3] <= 1'b1;
      at(850 * MS - 20, DUL, 1'b0);
      at(40, DUL, 1'b1);
      lamps.green[3] <= 1'b0;
      lamps.yellow[3] <= 1'b0;
      opts.gwVsYellowEn <= 1'b0;
      opts.vsRedEn <= 1'b1;
      clr();
      lamps.yellow[3] <= 1'b1;
      at(850 * MS - 20, DUL, 1'b0);
      at(40, DUL, 1'b1);
      opts.chanInclude[3] <= 1'b0;
      clr();
      at(900 * MS, DUL, 1'b0);
      lamps.yellow[3] <= 1'b0;
      opts.vsRedEn <= 1'b0;
      opts.chanInclude[3] <= 1'b1;
      done("dual indication");
      opts.watchdogEn <= 1'b1;
      at(200, WDG, 1'b0);
      stallCmd <= 1'b1;
      at(50, WDG, 1'b0);
      at(60, WDG, 1'b1);
      stallCmd <= 1'b0;
      at(100, WDG, 1'b1);
      clr();
      at(4, WDG, 1'b0);
      opts.watchdogEn <= 1'b0;
      done("watchdog");
      reset_n <= 1'b0;
      opts.minFlashSec <= 4'h0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      at(12, RLY, 1'b1);
      done("zero min flash");
      close_out();
   end
endmodule
`default_nettype wire
